// ==== hw/bsc_link.sv ====
// Serial shift engine running on the master's serial clock
`timescale 1ns/1ps
module bsc_link (
	// Reset
	input  wire logic       i_rst_n,
	// Serial pins
	input  wire logic       i_sck,
	input  wire logic       i_csn,
	input  wire logic       i_si,
	// Frame data
	input  wire logic [7:0] i_resp,
	output logic      [7:0] o_rx,
	output logic            o_so,
	output logic            o_started
);

	typedef struct packed {
		logic [7:0] rx;
	} bsc_rx_t;

	typedef struct packed {
		logic       started;
		logic       so;
		logic [6:0] tx;
	} bsc_tx_t;

	bsc_rx_t rx_q, rx_d;
	bsc_tx_t tx_q, tx_d;

	// Input sampled on falling edges, MSB first
	always_comb begin
		rx_d    = rx_q;
		rx_d.rx = {rx_q.rx[6:0], i_si};
	end

	always_ff @(negedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_q <= '0;
		end else begin
			rx_q <= rx_d;
		end
	end

	// Response is quasi-static: the system side only changes it after a frame
	always_comb begin
		tx_d = tx_q;
		if (!tx_q.started) begin
			tx_d.started = 1'b1;
			tx_d.so      = i_resp[7];
			tx_d.tx      = i_resp[6:0];
		end else begin
			tx_d.so = tx_q.tx[6];
			tx_d.tx = {tx_q.tx[5:0], 1'b0};
		end
	end

	// Chip select high ends the frame, whatever the clock count
	always_ff @(posedge i_sck or posedge i_csn) begin
		if (i_csn) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	assign o_rx      = rx_q.rx;
	assign o_so      = tx_q.so;
	assign o_started = tx_q.started;

endmodule : bsc_link

// ==== hw/bsc_pkg.sv ====
// Shared constants of the bridge serial command block
package bsc_pkg;

	// Command codes in the upper three bits of a received byte
	localparam logic [2:0] CMD_RD_FAULT         = 3'h0;
	localparam logic [2:0] CMD_RD_VER           = 3'h1;
	localparam logic [2:0] CMD_RD_CTRL          = 3'h3;
	localparam logic [2:0] CMD_CLR_FAULT        = 3'h4;
	localparam logic [2:0] CMD_WR_CTRL_RD_FAULT = 3'h6;
	localparam logic [2:0] CMD_WR_CTRL          = 3'h7;

	// Byte layout
	localparam int         FRAME_BITS   = 8;
	localparam int         CMD_MSB      = 7;
	localparam int         CMD_LSB      = 5;
	localparam int         DATA_MSB     = 4;

	// Output control word fields
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam int         CTRL_LEAD_OFF   = 4;
	localparam int         CTRL_SERIAL_SEL = 3;
	localparam int         CTRL_SERIAL_EN  = 2;
	localparam int         CTRL_SERIAL_DIR = 1;
	localparam int         CTRL_SERIAL_PWM = 0;

	// Fault status word fields
	localparam logic [7:0] DIAG_RESET      = 8'hDF;
	localparam int         DIAG_ACTIVE     = 7;
	localparam int         DIAG_THERMAL_OK = 6;
	localparam int         DIAG_FRAME_CHK  = 5;
	localparam int         DIAG_LIMIT_OFF  = 4;

	// Fault codes; each short clears one bit of the no-fault code
	localparam logic [3:0] CODE_NONE   = 4'hF;
	localparam logic [3:0] CODE_LEAD   = 4'hC;
	localparam logic [3:0] CODE_SUPPLY = 4'h3;
	localparam logic [3:0] MASK_GND1   = 4'h1;
	localparam logic [3:0] MASK_BAT1   = 4'h2;
	localparam logic [3:0] MASK_GND2   = 4'h4;
	localparam logic [3:0] MASK_BAT2   = 4'h8;

	// Version word upper nibble
	localparam logic [3:0] VER_UPPER = 4'h2;

	// Consecutive pulses for open lead set and release
	localparam logic [2:0] LEAD_PULSES = 3'h5;

	// Pin vector indices
	localparam int PIN_CSN = 0;
	localparam int PIN_SI  = 1;
	localparam int PIN_OFF = 2;
	localparam int PIN_PWM = 3;
	localparam int PIN_DIR = 4;
	localparam int PIN_N   = 5;
	localparam logic [4:0] PIN_RESET = 5'h01;

endpackage : bsc_pkg

// ==== hw/bsc_top.sv ====
// Serial command decoder, control word and fault status word of the bridge driver
// Functional notes
// - Decode command by upper three bits
// - Write control command loads and returns control
// - Write-control-read-fault returns fault status
// - Clear command resets faults, returns status
// - First answer after power-up is version
// - Unknown commands answer fault status
// - Control upper bits keep last control command code
// - Lead check off disconnects diagnostic source
// - Drive select picks pins or serial bits
// - Drive select sets only with pins low
// - Any bridge command pin change clears drive select
// - Serial enable gates outputs when selected
// - Serial bits act as direction and pwm
// - Bit 7 shows bridge off pin low
// - Bit 6 low during thermal shutdown
// - Bit 4 low after current limitation
// - Bit 5 always reads zero
// - Fault code uses listed values only
// - Shorts latched, lead and supply follow
// - Power-up, undervoltage, sleep clear faults
// - Enable toggle or clear command clears faults
// - Direction change clears limit and lead
// - Eight bit frames, one per select low
// - Sample falling edge, update rising edge
// - Error flag shown before first clock
`timescale 1ns/1ps
module bsc_top #(
	parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
	// System clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	// Serial link
	input  wire logic       i_sck,
	input  wire logic       i_csn,
	input  wire logic       i_si,
	output logic            o_so,
	// Bridge command pins
	input  wire logic       i_bridge_off_pin,
	input  wire logic       i_pwm,
	input  wire logic       i_direction_pin,
	// Fault sensing, system clock domain
	input  wire logic [1:0] i_ground_short,
	input  wire logic [1:0] i_battery_short,
	input  wire logic       i_limit_active,
	input  wire logic       i_thermal_shutdown,
	input  wire logic       i_supply_low,
	input  wire logic       i_sleep,
	input  wire logic       i_lead_open_off,
	input  wire logic       i_lead_pulse_miss,
	input  wire logic       i_lead_pulse_ok,
	// Bridge logic controls
	output logic            o_bridge_en_q,
	output logic            o_bridge_pwm_q,
	output logic            o_bridge_dir_q,
	output logic            o_lead_source_on_q,
	output logic [7:0]      o_control_word_q,
	output logic [7:0]      o_fault_word_q
);

	typedef struct packed {
		logic [bsc_pkg::PIN_N-1:0] s1;
		logic [bsc_pkg::PIN_N-1:0] s2;
		logic [bsc_pkg::PIN_N-1:0] s3;
		logic [bsc_pkg::PIN_N-1:0] pin;
		logic [7:0]                ctrl;
		logic [3:0]                shorts;
		logic                      limit;
		logic [2:0]                miss_cnt;
		logic [2:0]                ok_cnt;
		logic                      lead_on;
		logic                      en_prev;
		logic                      dir_prev;
		logic [7:0]                resp;
		logic [7:0]                diag;
		logic                      err_flag;
		logic                      bridge_en;
		logic                      bridge_pwm;
		logic                      bridge_dir;
		logic                      src_on;
	} bsc_state_t;

	bsc_state_t q, d;

	logic [7:0] link_rx;
	logic       link_so;
	logic       link_started;

	bsc_link u_link (
		.i_rst_n   (i_rst_n),
		.i_sck     (i_sck),
		.i_csn     (i_csn),
		.i_si      (i_si),
		.i_resp    (q.resp),
		.o_rx      (link_rx),
		.o_so      (link_so),
		.o_started (link_started)
	);

	// Fault code from latched shorts; unlisted pairs keep the ground short
	function automatic logic [3:0] bsc_code(input logic [3:0] sh, input logic lead,
	                                        input logic low);
		logic [3:0] code;
		code = bsc_pkg::CODE_NONE;
		if (sh[0]) begin
			code = code & ~bsc_pkg::MASK_GND1;
		end else if (sh[1]) begin
			code = code & ~bsc_pkg::MASK_BAT1;
		end
		if (sh[2]) begin
			code = code & ~bsc_pkg::MASK_GND2;
		end else if (sh[3]) begin
			code = code & ~bsc_pkg::MASK_BAT2;
		end
		if (low) begin
			code = bsc_pkg::CODE_SUPPLY;
		end else if (code == bsc_pkg::CODE_NONE && lead) begin
			code = bsc_pkg::CODE_LEAD;
		end
		return code;
	endfunction : bsc_code

	always_comb begin
		logic [bsc_pkg::PIN_N-1:0] pin_in;
		logic                      frame_end;
		logic [2:0]                cmd;
		logic                      wr;
		logic                      pins_low;
		logic                      pin_change;
		logic                      sel;
		logic                      en_eff;
		logic                      dir_eff;
		logic                      dir_change;
		logic                      clr;
		logic                      shutdown;
		logic                      lead_now;
		logic [3:0]                sh_set;
		logic [7:0]                diag_now;

		d = q;

		// Three-stage pin synchronisers; a change counts once stages two and three agree
		pin_in                   = '0;
		pin_in[bsc_pkg::PIN_CSN] = i_csn;
		pin_in[bsc_pkg::PIN_SI]  = i_si;
		pin_in[bsc_pkg::PIN_OFF] = i_bridge_off_pin;
		pin_in[bsc_pkg::PIN_PWM] = i_pwm;
		pin_in[bsc_pkg::PIN_DIR] = i_direction_pin;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < bsc_pkg::PIN_N; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.pin[i] = q.s3[i];
			end
		end
		pin_change = (d.pin[bsc_pkg::PIN_OFF] != q.pin[bsc_pkg::PIN_OFF])
		           | (d.pin[bsc_pkg::PIN_PWM] != q.pin[bsc_pkg::PIN_PWM])
		           | (d.pin[bsc_pkg::PIN_DIR] != q.pin[bsc_pkg::PIN_DIR]);
		pins_low   = ~q.pin[bsc_pkg::PIN_OFF] & ~q.pin[bsc_pkg::PIN_PWM]
		           & ~q.pin[bsc_pkg::PIN_DIR];

		// Frame ends on the filtered select rising edge; the clock is idle by then
		frame_end = d.pin[bsc_pkg::PIN_CSN] & ~q.pin[bsc_pkg::PIN_CSN];
		cmd       = link_rx[bsc_pkg::CMD_MSB:bsc_pkg::CMD_LSB];
		wr        = frame_end & (cmd == bsc_pkg::CMD_WR_CTRL
		                         || cmd == bsc_pkg::CMD_WR_CTRL_RD_FAULT);

		// Control word update
		if (wr) begin
			d.ctrl[bsc_pkg::DATA_MSB:0] = link_rx[bsc_pkg::DATA_MSB:0];
			if (!pins_low) begin
				d.ctrl[bsc_pkg::CTRL_SERIAL_SEL] = q.ctrl[bsc_pkg::CTRL_SERIAL_SEL];
			end
		end
		if (frame_end && (wr || cmd == bsc_pkg::CMD_RD_CTRL)) begin
			d.ctrl[bsc_pkg::CMD_MSB:bsc_pkg::CMD_LSB] = cmd;
		end
		if (pin_change) begin
			d.ctrl[bsc_pkg::CTRL_SERIAL_SEL] = 1'b0;
		end

		// Bridge command source
		sel     = d.ctrl[bsc_pkg::CTRL_SERIAL_SEL];
		en_eff  = sel ? d.ctrl[bsc_pkg::CTRL_SERIAL_EN] : ~d.pin[bsc_pkg::PIN_OFF];
		dir_eff = sel ? d.ctrl[bsc_pkg::CTRL_SERIAL_DIR] : d.pin[bsc_pkg::PIN_DIR];
		d.bridge_pwm = sel ? d.ctrl[bsc_pkg::CTRL_SERIAL_PWM] : d.pin[bsc_pkg::PIN_PWM];
		d.bridge_dir = dir_eff;
		d.en_prev    = en_eff;
		d.dir_prev   = dir_eff;
		dir_change   = dir_eff != q.dir_prev;

		// Clearing events: supply, sleep, enable re-applied, clear command
		clr = i_supply_low | i_sleep
		    | (en_eff & ~q.en_prev)
		    | (frame_end & (cmd == bsc_pkg::CMD_CLR_FAULT));

		// Latched shorts; a new fault in the clearing cycle survives
		sh_set   = {i_battery_short[1], i_ground_short[1], i_battery_short[0],
		            i_ground_short[0]};
		d.shorts = (clr ? 4'h0 : q.shorts) | sh_set;
		d.limit  = ((clr | dir_change) ? 1'b0 : q.limit) | i_limit_active;

		// Open lead while driving: five missed pulses set, five good pulses release
		if (clr || dir_change) begin
			d.miss_cnt = '0;
			d.ok_cnt   = '0;
			d.lead_on  = 1'b0;
		end
		if (i_lead_pulse_miss) begin
			d.ok_cnt = '0;
			if (d.miss_cnt != bsc_pkg::LEAD_PULSES) begin
				d.miss_cnt = d.miss_cnt + 3'h1;
			end
			if (d.miss_cnt == bsc_pkg::LEAD_PULSES) begin
				d.lead_on = 1'b1;
			end
		end else if (i_lead_pulse_ok) begin
			d.miss_cnt = '0;
			if (d.ok_cnt != bsc_pkg::LEAD_PULSES) begin
				d.ok_cnt = d.ok_cnt + 3'h1;
			end
			if (d.ok_cnt == bsc_pkg::LEAD_PULSES) begin
				d.lead_on = 1'b0;
			end
		end

		// Open lead is live, and hidden when the diagnostic source is off
		lead_now = (d.lead_on | (d.pin[bsc_pkg::PIN_OFF] & i_lead_open_off))
		         & ~d.ctrl[bsc_pkg::CTRL_LEAD_OFF];
		d.src_on = ~d.ctrl[bsc_pkg::CTRL_LEAD_OFF];

		// Fault status word
		diag_now                           = bsc_pkg::DIAG_RESET;
		diag_now[bsc_pkg::DIAG_ACTIVE]     = ~d.pin[bsc_pkg::PIN_OFF];
		diag_now[bsc_pkg::DIAG_THERMAL_OK] = ~i_thermal_shutdown;
		diag_now[bsc_pkg::DIAG_FRAME_CHK]  = 1'b0;
		diag_now[bsc_pkg::DIAG_LIMIT_OFF]  = ~d.limit;
		diag_now[3:0]                      = bsc_code(d.shorts, lead_now, i_supply_low);
		d.diag                             = diag_now;

		// Outputs off on any shutdown, not only on disable
		shutdown    = (|d.shorts) | i_thermal_shutdown | i_supply_low | i_sleep;
		d.bridge_en = en_eff & ~shutdown;
		d.err_flag  = ~d.bridge_en | d.pin[bsc_pkg::PIN_SI];

		// Answer latched for the next frame
		if (frame_end) begin
			case (cmd)
				bsc_pkg::CMD_RD_VER: begin
					d.resp = {bsc_pkg::VER_UPPER, REVISION};
				end
				bsc_pkg::CMD_RD_CTRL, bsc_pkg::CMD_WR_CTRL: begin
					d.resp = d.ctrl;
				end
				bsc_pkg::CMD_RD_FAULT, bsc_pkg::CMD_CLR_FAULT,
				bsc_pkg::CMD_WR_CTRL_RD_FAULT: begin
					d.resp = diag_now;
				end
				default: begin
					d.resp = diag_now;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q            <= '0;
			q.s1         <= bsc_pkg::PIN_RESET;
			q.s2         <= bsc_pkg::PIN_RESET;
			q.s3         <= bsc_pkg::PIN_RESET;
			q.pin        <= bsc_pkg::PIN_RESET;
			q.ctrl       <= bsc_pkg::CTRL_RESET;
			q.diag       <= bsc_pkg::DIAG_RESET;
			q.resp       <= {bsc_pkg::VER_UPPER, REVISION};
			q.err_flag   <= 1'b1;
			q.src_on     <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Select between flag phase and shifted data; both sides are flops
	assign o_so               = link_started ? link_so : q.err_flag;
	assign o_bridge_en_q      = q.bridge_en;
	assign o_bridge_pwm_q     = q.bridge_pwm;
	assign o_bridge_dir_q     = q.bridge_dir;
	assign o_lead_source_on_q = q.src_on;
	assign o_control_word_q   = q.ctrl;
	assign o_fault_word_q     = q.diag;

endmodule : bsc_top

// ==== verification/bsc_master.sv ====
// Serial master model that frames one byte at a time
`timescale 1ns/1ps
module bsc_master (
	input  wire logic i_clk_link,
	input  wire logic i_so,
	output logic      o_sck,
	output logic      o_csn,
	output logic      o_si
);
	initial begin
		o_sck = 1'b0;
		o_csn = 1'b1;
		o_si  = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ef);
		@(posedge i_clk_link);
		o_csn <= 1'b0;
		o_si  <= tx[7];
		// Flag is filtered in the system domain
		repeat (9) @(posedge i_clk_link);
		ef = i_so;
		for (int i = 7; i >= 0; i--) begin
			o_si  <= tx[i];
			o_sck <= 1'b1;
			@(posedge i_clk_link);
			rx[i] = i_so;
			o_sck <= 1'b0;
			@(posedge i_clk_link);
		end
		// Released line shows the inverse, never the last bit
		o_csn <= 1'b1;
		o_si  <= ~tx[0];
		repeat (12) @(posedge i_clk_link);
	endtask : xfer
endmodule : bsc_master

// ==== verification/bsc_properties.sv ====
// Checker of the bridge serial command block
`timescale 1ns/1ps
module bsc_props (
	// Clock and reset
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	// Watched ports
	input wire logic       i_bridge_off_pin,
	input wire logic       i_pwm,
	input wire logic       i_direction_pin,
	input wire logic [1:0] i_ground_short,
	input wire logic       i_thermal_shutdown,
	input wire logic       i_supply_low,
	input wire logic       o_bridge_pwm_q,
	input wire logic       o_bridge_dir_q,
	input wire logic       o_lead_source_on_q,
	input wire logic [7:0] o_control_word_q,
	input wire logic [7:0] o_fault_word_q
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	a_frame_zero: assert property (!o_fault_word_q[5])
		else $error("bit5 set");
	a_code_legal: assert property (o_fault_word_q[3:0] inside
		{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6, 4'h5, 4'h3})
		else $error("bad code");
	// Pin passes synchronisers first, so wait for it to settle
	a_active_flag: assert property ($stable(i_bridge_off_pin) [*8] |->
		o_fault_word_q[7] != i_bridge_off_pin) else $error("bad bit7");
	a_thermal_low: assert property (i_thermal_shutdown [*2] |-> !o_fault_word_q[6])
		else $error("bit6 high");
	a_short_latch: assert property (i_ground_short[0] && !i_supply_low |=>
		!o_fault_word_q[0]) else $error("short lost");
	a_serial_bits: assert property (o_control_word_q[3] && $stable(o_control_word_q) |->
		{o_bridge_dir_q, o_bridge_pwm_q} == o_control_word_q[1:0]) else $error("bad drive");
	a_pin_clear: assert property ($changed({i_bridge_off_pin, i_pwm, i_direction_pin}) |->
		##[1:8] !o_control_word_q[3]) else $error("select kept");
	a_lead_off: assert property (o_control_word_q[4] [*2] |-> !o_lead_source_on_q)
		else $error("source on");
	c_short: cover property (!o_fault_word_q[0]);
	c_serial: cover property (o_control_word_q[3]);
	c_supply: cover property (o_fault_word_q[3:0] == 4'h3);
endmodule : bsc_props

bind bsc_top bsc_props u_props (.i_clk_sys, .i_rst_n, .i_bridge_off_pin, .i_pwm,
	.i_direction_pin, .i_ground_short, .i_thermal_shutdown, .i_supply_low, .o_bridge_pwm_q,
	.o_bridge_dir_q, .o_lead_source_on_q, .o_control_word_q, .o_fault_word_q);

// ==== verification/testbench.sv ====
// Self-checking bench of the bridge serial command block
`timescale 1ns/1ps
module testbench;
	localparam logic [3:0] REV = 4'h9; // Arbitrary value
	logic        i_clk_sys = 1'b0;
	logic        clk_link = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        sck, csn, si, so, en, bpwm, bdir, ef;
	logic        off = 1'b0, pwm = 1'b0, dir = 1'b0, lim = 1'b0, thr = 1'b0;
	logic        sup = 1'b0, slp = 1'b0, miss = 1'b0, ok = 1'b0, lof = 1'b0, src;
	logic [1:0]  gnd = 2'h0, bat = 2'h0;
	logic [7:0]  cw, fw, rx, ctl = 8'h00, resp = {4'h2, REV};
	logic [15:0] lfsr = 16'h0005;
	int          errors = 0, comparisons = 0;

	always #5 i_clk_sys = ~i_clk_sys;
	initial begin
		#1.3;
		forever #3 clk_link = ~clk_link;
	end

	bsc_top #(.REVISION(REV)) DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_sck(sck), .i_csn(csn), .i_si(si), .o_so(so), .i_bridge_off_pin(off),
		.i_pwm(pwm), .i_direction_pin(dir), .i_ground_short(gnd), .i_battery_short(bat),
		.i_limit_active(lim), .i_thermal_shutdown(thr), .i_supply_low(sup), .i_sleep(slp),
		.i_lead_open_off(lof), .i_lead_pulse_miss(miss), .i_lead_pulse_ok(ok),
		.o_bridge_en_q(en), .o_bridge_pwm_q(bpwm), .o_bridge_dir_q(bdir),
		.o_lead_source_on_q(src), .o_control_word_q(cw), .o_fault_word_q(fw));
	bsc_master u_master (.i_clk_link(clk_link), .i_so(so), .o_sck(sck), .o_csn(csn), .o_si(si));

	function automatic logic [15:0] next_rand(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : next_rand

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask : tick

	// Sends one command; the answer seen belongs to the one before
	task automatic frame(input logic [7:0] tx);
		logic [7:0] nxt;
		logic       on;
		on = ctl[3] ? ctl[2] : 1'b1;
		u_master.xfer(tx, rx, ef);
		check({7'h0, ef}, {7'h0, ~on | tx[7]});
		check(rx, resp);
		nxt = 8'hDF;
		case (tx[7:5])
			3'h1: nxt = {4'h2, REV};
			3'h3: begin
				ctl[7:5] = 3'h3;
				nxt = ctl;
			end
			3'h6, 3'h7: begin
				ctl = {tx[7:4], tx[3] & ~(off | pwm | dir), tx[2:0]};
				if (tx[5])
					nxt = ctl;
			end
			default: ;
		endcase
		resp = nxt;
		tick(2);
		check(cw, ctl);
	endtask : frame

	initial begin
		tick(6);
		i_rst_n <= 1'b1;
		check(cw, 8'h00);
		check(fw, 8'hDF);
		tick(6);
		for (int k = 0; k < 24; k++) begin
			lfsr = next_rand(lfsr);
			frame({k[2:0], lfsr[4:0]});
		end
		$display("test commands done");
		pwm <= 1'b1;
		ctl[3] = 1'b0;
		tick(8);
		frame(8'hE8);
		pwm <= 1'b0;
		tick(8);
		// Serial direction low, so the pin going high is a real direction change
		frame(8'hED);
		check({5'h0, en, bdir, bpwm}, 8'h05);
		lim <= 1'b1;
		tick(1);
		lim <= 1'b0;
		tick(3);
		check(fw, 8'hCF);
		dir <= 1'b1;
		ctl[3] = 1'b0;
		tick(8);
		check(cw, ctl);
		check(fw, 8'hDF);
		dir <= 1'b0;
		tick(8);
		frame(8'hE0);
		thr <= 1'b1;
		tick(3);
		check(fw, 8'h9F);
		thr <= 1'b0;
		sup <= 1'b1;
		tick(3);
		check(fw, 8'hD3);
		sup <= 1'b0;
		tick(3);
		check(fw, 8'hDF);
		for (int j = 0; j < 10; j++) begin
			{miss, ok} <= {j < 5, j > 4};
			tick(1);
			{miss, ok} <= 2'h0;
			tick(3);
			if (j % 5 == 4)
				check(fw, j < 5 ? 8'hDC : 8'hDF);
		end
		lof <= 1'b1;
		off <= 1'b1;
		tick(8);
		check(fw, 8'h5C);
		check({7'h0, src}, 8'h01);
		off <= 1'b0;
		tick(8);
		check(fw, 8'hDF);
		lof <= 1'b0;
		$display("test status flags done");
		// Pattern bits are out2 battery, out2 ground, out1 battery, out1 ground
		for (logic [3:0] p = 4'h1; p < 4'hB; p++) begin
			if (p[1:0] == 2'h3)
				continue;
			{bat[1], gnd[1], bat[0], gnd[0]} <= p;
			tick(1);
			{gnd, bat} <= 4'h0;
			tick(3);
			check(fw, {4'hD, ~p});
			case (p % 3)
				0: frame(8'h80);
				1: begin
					off <= 1'b1;
					tick(8);
					check({7'h0, fw[7]}, 8'h00);
					off <= 1'b0;
					tick(8);
				end
				default: begin
					slp <= 1'b1;
					tick(2);
					slp <= 1'b0;
					tick(2);
				end
			endcase
			tick(2);
			check(fw, 8'hDF);
		end
		frame(8'h00);
		$display("test fault latching done");
		test_done();
	end
endmodule : testbench
